// ===== hw/srw_pending.sv
// Holds one frame-synchronised write until vertical sync falls.
// Assumes the write pulse and the sync fall are on clk_in.
`timescale 1ns/1ps
`default_nettype none
module srw_pending (
    // Clock and control
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic                ce_in,
    // Write in, fall event
    input  wire srw_pkg::srw_write_t wr_in,
    input  wire logic                vsync_fall_in,
    // Applied write
    output srw_pkg::srw_write_t      apply_out
);
    srw_pkg::srw_write_t hold_reg;
    srw_pkg::srw_write_t apply_reg;
    // Last write before the fall wins; a write in the fall cycle is applied
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            hold_reg  <= '0;
            apply_reg <= '0;
        end else if (ce_in) begin
            apply_reg.valid <= 1'b0;
            if (vsync_fall_in && (hold_reg.valid || wr_in.valid)) begin
                apply_reg <= wr_in.valid ? wr_in : hold_reg; // RL17
                hold_reg  <= '0;
            end else if (wr_in.valid) begin
                hold_reg <= wr_in;
            end
        end
    end
    assign apply_out = apply_reg;
endmodule // srw_pending
`default_nettype wire

// ===== hw/srw_port.sv
// Serial register write port: shifter, map decode, counts register.
// Assumes serial pins asynchronous; clock-enable gates all state.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1 - Each write is a 12-bit address then a 28-bit data word.
// RL2 - Address and data arrive least significant bit first.
// RL3 - A single write is 40 bits under a low load strobe.
// RL4 - Host pads unused upper data bits with zeros.
// RL5 - Strobe ending early leaves the target register unchanged.
// RL6 - Further whole words go to the next higher address.
// RL7 - Continuous writes may start at any address.
// RL8 - Host keeps strobe low until the last word is in.
// RL9 - Fixed area 0x00-0xFF, configurable area from 0x800.
// RL10 - Register 0x28 holds group and sequence counts setting boundaries.
// RL11 - Pattern groups start at 0x800, 48 addresses each.
// RL12 - Sequences start after groups, 40 addresses each.
// RL13 - Fields start after sequences, 16 addresses each.
// RL14 - The three regions are packed with no gaps.
// RL15 - Host avoids undefined fixed addresses.
// RL16 - Immediate registers update when the final data bit arrives.
// RL17 - Frame registers apply at the next vertical sync fall.
// RL18 - Sample on serial clock rise while strobe low; rise ends.
// RL19 - Address precedes data; counter clears when strobe high.
module srw_port (
    // Clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        ce_in,
    // Serial pins
    input  wire logic        sclk_in,
    input  wire logic        sdata_in,
    input  wire logic        load_strobe_n_in,
    // Vertical sync pin
    input  wire logic        vertical_sync_in,
    // Selects frame-synchronised class for the current write
    input  wire logic        frame_class_in,
    // Immediate and frame-synchronised writes out
    output logic             imm_valid_out,
    output logic [11:0]      imm_addr_out,
    output logic [27:0]      imm_data_out,
    output logic             frm_valid_out,
    output logic [11:0]      frm_addr_out,
    output logic [27:0]      frm_data_out,
    // Decoded region of the last write
    output logic [1:0]       region_out,
    output logic             mapped_out,
    output logic [11:0]      offset_out,
    // Counts register and region starts
    output logic [27:0]      counts_out,
    output logic [11:0]      seq_base_out,
    output logic [11:0]      fld_base_out
);
    logic [2:0] pins_sync;
    logic       sclk_s;
    logic       sdata_s;
    logic       strobe_n_s;
    logic       sclk_d_reg;
    logic       vs_sync_reg;
    logic       vs_meta_reg;
    logic       vs_d_reg;
    logic       sclk_rise;
    logic       vs_fall;
    logic [5:0] bit_cnt_reg;
    logic       in_data_reg;
    logic [11:0] addr_reg;
    logic [27:0] shift_reg;
    logic [27:0] counts_reg;
    logic [27:0] word_next;
    logic        word_done;
    srw_pkg::srw_write_t wr_now;
    srw_pkg::srw_write_t frm_wr;
    srw_pkg::srw_write_t frm_apply;
    srw_pkg::srw_decode_t dec_reg;

    // Region start for a count times a span
    function automatic logic [11:0] span_of(input logic [7:0] n, input logic [11:0] span);
        logic [19:0] p;
        p = 20'(n) * 20'(span);
        return p[11:0];
    endfunction

    // Classify an address against the configurable layout
    function automatic srw_pkg::srw_decode_t decode(input logic [11:0] a, input logic [11:0] sb,
                                                    input logic [11:0] fb);
        srw_pkg::srw_decode_t d;
        d = '0;
        if (a <= srw_pkg::FIXED_LAST) begin // RL9
            d.region = srw_pkg::SRW_RGN_FIXED;
            d.mapped = 1'b1;
            d.offset = a;
        end else if (a >= srw_pkg::CFG_BASE && a < sb) begin // RL11
            d.region = srw_pkg::SRW_RGN_PAT;
            d.mapped = 1'b1;
            d.offset = a - srw_pkg::CFG_BASE;
        end else if (a >= sb && a < fb) begin // RL12
            d.region = srw_pkg::SRW_RGN_SEQ;
            d.mapped = 1'b1;
            d.offset = a - sb;
        end else if (a >= fb) begin // RL13
            d.region = srw_pkg::SRW_RGN_FLD;
            d.mapped = 1'b1;
            d.offset = a - fb;
        end
        return d;
    endfunction

    srw_sync u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .raw_in     ({sclk_in, sdata_in, load_strobe_n_in}),
        .sync_out   (pins_sync)
    );
    assign sclk_s     = pins_sync[2];
    assign sdata_s    = pins_sync[1];
    assign strobe_n_s = pins_sync[0];

    // Edge history on synchronised pins only
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sclk_d_reg  <= 1'b1;
            vs_meta_reg <= 1'b1;
            vs_sync_reg <= 1'b1;
            vs_d_reg    <= 1'b1;
        end else if (ce_in) begin
            sclk_d_reg  <= sclk_s;
            vs_meta_reg <= vertical_sync_in;
            vs_sync_reg <= vs_meta_reg;
            vs_d_reg    <= vs_sync_reg;
        end
    end
    assign sclk_rise = sclk_s && !sclk_d_reg && !strobe_n_s; // RL18
    assign vs_fall   = vs_d_reg && !vs_sync_reg;

    // Shifting: new bits enter at the top so the first bit lands at bit 0
    assign word_next = {sdata_s, shift_reg[27:1]}; // RL2
    assign word_done = sclk_rise && in_data_reg && bit_cnt_reg == 6'(srw_pkg::DATA_W - 1);

    // Bit counter and address/data phase
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            bit_cnt_reg <= 6'h00;
            in_data_reg <= 1'b0;
            addr_reg    <= 12'h000;
            shift_reg   <= 28'h0000000;
        end else if (ce_in) begin
            if (strobe_n_s) begin
                bit_cnt_reg <= 6'h00; // RL19
                in_data_reg <= 1'b0;  // RL5
            end else if (sclk_rise) begin
                shift_reg <= word_next;
                if (!in_data_reg) begin
                    addr_reg <= {sdata_s, addr_reg[11:1]}; // RL2
                    if (bit_cnt_reg == 6'(srw_pkg::ADDR_W - 1)) begin // RL1
                        bit_cnt_reg <= 6'h00;
                        in_data_reg <= 1'b1; // RL19
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 6'h01;
                    end
                end else if (word_done) begin
                    bit_cnt_reg <= 6'h00; // RL6
                    addr_reg    <= addr_reg + 12'h001; // RL6 RL7
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 6'h01;
                end
            end
        end
    end

    // Complete word only; a short word never produces a write
    always_comb begin
        wr_now       = '0;
        wr_now.valid = word_done; // RL5 RL16
        wr_now.addr  = addr_reg;
        wr_now.data  = word_next;
        frm_wr       = wr_now;
        frm_wr.valid = word_done && frame_class_in;
    end

    // Immediate write outputs
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            imm_valid_out <= 1'b0;
            imm_addr_out  <= 12'h000;
            imm_data_out  <= 28'h0000000;
        end else if (ce_in) begin
            imm_valid_out <= word_done && !frame_class_in; // RL16
            if (word_done && !frame_class_in) begin
                imm_addr_out <= wr_now.addr;
                imm_data_out <= wr_now.data;
            end
        end
    end

    srw_pending u_pending (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .ce_in         (ce_in),
        .wr_in         (frm_wr),
        .vsync_fall_in (vs_fall),
        .apply_out     (frm_apply)
    );
    assign frm_valid_out = frm_apply.valid;
    assign frm_addr_out  = frm_apply.addr;
    assign frm_data_out  = frm_apply.data;

    // Counts register updates on its word, immediately
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            counts_reg <= srw_pkg::COUNTS_RESET;
        end else if (ce_in && word_done && addr_reg == srw_pkg::COUNTS_ADDR) begin
            counts_reg <= word_next; // RL10
        end
    end
    assign counts_out = counts_reg;

    // Packed back to back: each start is the previous end
    always_comb begin
        seq_base_out = srw_pkg::CFG_BASE
                     + span_of(counts_reg[srw_pkg::PAT_LSB +: srw_pkg::CNT_FLD_W], srw_pkg::PAT_SPAN); // RL12 RL14
        fld_base_out = seq_base_out
                     + span_of(counts_reg[srw_pkg::SEQ_LSB +: srw_pkg::CNT_FLD_W], srw_pkg::SEQ_SPAN); // RL13 RL14
    end

    // Region of each completed write, held until the next
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dec_reg <= '0;
        end else if (ce_in && word_done) begin
            dec_reg <= decode(addr_reg, seq_base_out, fld_base_out); // RL9
        end
    end
    assign region_out = dec_reg.region;
    assign mapped_out = dec_reg.mapped;
    assign offset_out = dec_reg.offset;
endmodule // srw_port
`default_nettype wire

// ===== hw/srw_sync.sv
// Two-flop synchroniser for the three serial pins.
// Assumes inputs are asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module srw_sync (
    // Clock and control
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       ce_in,
    // Raw and synchronised pins
    input  wire logic [2:0] raw_in,
    output logic      [2:0] sync_out
);
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    // First stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            meta_reg <= 3'h7;
            sync_reg <= 3'h7;
        end else if (ce_in) begin
            meta_reg <= raw_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule // srw_sync
`default_nettype wire

// ===== include/srw_pkg.sv
// Package for the serial register write port: widths, map and field layout.
// Assumes a single 125 MHz system clock domain.
`default_nettype none
package srw_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 28;
    localparam int FRAME_BITS = ADDR_W + DATA_W;
    localparam int CNT_W = 6;
    localparam logic [11:0] FIXED_LAST = 12'h0ff;
    localparam logic [11:0] CFG_BASE = 12'h800;
    localparam logic [11:0] COUNTS_ADDR = 12'h028;
    localparam logic [11:0] PAT_SPAN = 12'h030;
    localparam logic [11:0] SEQ_SPAN = 12'h028;
    localparam logic [11:0] FLD_SPAN = 12'h010;
    localparam int PAT_LSB = 0;
    localparam int SEQ_LSB = 8;
    localparam int CNT_FLD_W = 8;
    localparam logic [27:0] COUNTS_RESET = 28'h0000000;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        SRW_RGN_FIXED,
        SRW_RGN_PAT,
        SRW_RGN_SEQ,
        SRW_RGN_FLD
    } srw_region_t;
    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic [27:0] data;
    } srw_write_t;
    typedef struct packed {
        srw_region_t region;
        logic        mapped;
        logic [11:0] offset;
    } srw_decode_t;
endpackage
`default_nettype wire

// ===== testbench/srw_host.sv
// Host model shifting serial register writes into the port.
// Assumes the bench sequences frames through these tasks.
`timescale 1ns/1ps
`default_nettype none
module srw_host (
    // Serial pins
    output logic sclk_out,
    output logic sdata_out,
    output logic load_strobe_n_out
);
    localparam realtime HALF = 62.5;
    // Idle: clock still, strobe high
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        load_strobe_n_out = 1'b1;
    end
    // Strobe low opens a frame ahead of the first bit
    task automatic open_frame();
        load_strobe_n_out = 1'b0;
        #HALF;
    endtask
    // Data set half a period before each rise, held to the fall
    task automatic shift(input logic [39:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            sdata_out = v[i];
            #HALF sclk_out = 1'b1;
            #HALF sclk_out = 1'b0;
        end
    endtask
    // Strobe rise ends the frame; released data does not hold
    task automatic close_frame();
        #HALF load_strobe_n_out = 1'b1;
        sdata_out = ~sdata_out;
    endtask
endmodule // srw_host
`default_nettype wire

// ===== testbench/srw_port_chk.sv
// Checker for the serial register write port outputs.
// Assumes ce_in held high; bound to every srw_port.
`timescale 1ns/1ps
`default_nettype none
module srw_port_chk (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        sys_rst_in,
    // Pins
    input wire logic        load_strobe_n_in,
    input wire logic        vertical_sync_in,
    // Results
    input wire logic        imm_valid_out,
    input wire logic [11:0] imm_addr_out,
    input wire logic [27:0] imm_data_out,
    input wire logic        frm_valid_out,
    input wire logic [1:0]  region_out,
    input wire logic        mapped_out,
    input wire logic [11:0] offset_out,
    input wire logic [27:0] counts_out,
    input wire logic [11:0] seq_base_out,
    input wire logic [11:0] fld_base_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Map boundaries follow the counts register
    AST_SEQ_BASE: assert property (seq_base_out == 12'h800 + counts_out[7:0] * 12'h030) else $error("seq base");
    AST_FLD_BASE: assert property (fld_base_out == seq_base_out + counts_out[15:8] * 12'h028) else $error("fld base");
    // A word takes far longer than 8 cycles, so pulses stand alone
    AST_IMM_PULSE: assert property (imm_valid_out |=> (!imm_valid_out)[*8]) else $error("imm pulse");
    AST_IMM_STROBE: assert property (imm_valid_out |-> !$past(load_strobe_n_in, 2)) else $error("strobe");
    AST_COUNTS_WR: assert property (imm_valid_out && imm_addr_out == 12'h028 |-> counts_out == imm_data_out)
        else $error("counts write");
    AST_COUNTS_HOLD: assert property ($changed(counts_out) |-> imm_valid_out && imm_addr_out == 12'h028)
        else $error("counts hold");
    // Region decode of each immediate write, then the frame pulse after a vertical sync fall
    AST_FIXED: assert property (imm_valid_out && imm_addr_out <= 12'h0ff |-> mapped_out && region_out == 2'd0)
        else $error("fixed");
    AST_GAP: assert property (imm_valid_out && imm_addr_out inside {[12'h100:12'h7ff]} |-> !mapped_out)
        else $error("gap");
    AST_PAT: assert property (imm_valid_out && imm_addr_out >= 12'h800 && imm_addr_out < seq_base_out
        |-> region_out == 2'd1 && offset_out == imm_addr_out - 12'h800) else $error("pat");
    AST_SEQ: assert property (imm_valid_out && imm_addr_out >= seq_base_out && imm_addr_out < fld_base_out
        |-> region_out == 2'd2 && offset_out == imm_addr_out - seq_base_out) else $error("seq");
    AST_FLD: assert property (imm_valid_out && imm_addr_out >= fld_base_out && fld_base_out >= 12'h800
        |-> region_out == 2'd3 && offset_out == imm_addr_out - fld_base_out) else $error("fld");
    AST_FRM: assert property (frm_valid_out |-> !$past(vertical_sync_in, 2) ##1 !frm_valid_out)
        else $error("frame pulse");
    // Main scenarios reached
    COV_COUNTS: cover property (imm_valid_out && imm_addr_out == 12'h028);
    COV_FLD: cover property (imm_valid_out && region_out == 2'd3);
    COV_FRM: cover property (frm_valid_out);
endmodule // srw_port_chk
bind srw_port srw_port_chk srw_port_chk_i (.clk_in, .sys_rst_in, .load_strobe_n_in, .vertical_sync_in,
    .imm_valid_out, .imm_addr_out, .imm_data_out, .frm_valid_out, .region_out, .mapped_out,
    .offset_out, .counts_out, .seq_base_out, .fld_base_out);
`default_nettype wire

// ===== testbench/srw_port_tb.sv
// Top testbench for the serial register write port.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module srw_port_tb;
    logic        clk_in, sys_rst_in, vertical_sync_in, frame_class_in, sclk, sdata, strobe_n;
    logic        imm_valid_out, frm_valid_out, mapped_out;
    logic [11:0] imm_addr_out, frm_addr_out, offset_out, seq_base_out, fld_base_out;
    logic [27:0] imm_data_out, frm_data_out, counts_out;
    logic [1:0]  region_out;
    logic [7:0]  pat, sq;
    logic [54:0] seen[$];
    logic [11:0] starts[3] = '{12'h88f, 12'h92f, 12'h800};
    int          mismatches, num_checks, nfrm;

    srw_port srw_port_i (.clk_in, .sys_rst_in, .ce_in(1'b1), .sclk_in(sclk), .sdata_in(sdata),
        .load_strobe_n_in(strobe_n), .vertical_sync_in, .frame_class_in, .imm_valid_out, .imm_addr_out,
        .imm_data_out, .frm_valid_out, .frm_addr_out, .frm_data_out, .region_out, .mapped_out,
        .offset_out, .counts_out, .seq_base_out, .fld_base_out);
    srw_host srw_host_i (.sclk_out(sclk), .sdata_out(sdata), .load_strobe_n_out(strobe_n));

    // 125 MHz system clock
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // Capture write pulses; registered outputs are stable here
    always @(posedge clk_in) begin
        if (imm_valid_out === 1'b1) seen.push_back({imm_addr_out, imm_data_out, region_out, mapped_out, offset_out});
        if (frm_valid_out === 1'b1) nfrm++;
    end
    task automatic check(input string name, input logic [54:0] got, input logic [54:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Expected decode of a mapped write under the current counts
    function automatic logic [54:0] ent(input logic [11:0] a, input logic [27:0] d);
        logic [11:0] sb;
        logic [11:0] fb;
        sb = 12'h800 + pat * 12'd48;
        fb = sb + sq * 12'd40;
        if (a >= fb) return {a, d, 2'd3, 1'b1, a - fb};
        if (a >= sb) return {a, d, 2'd2, 1'b1, a - sb};
        if (a >= 12'h800) return {a, d, 2'd1, 1'b1, a - 12'h800};
        return {a, d, 2'd0, 1'b1, a};
    endfunction
    // Address, n whole words, then an optional cut-short tail
    task automatic frame(input logic [11:0] a, input logic [27:0] d0, input int n, input int extra);
        srw_host_i.open_frame();
        srw_host_i.shift({28'h0, a}, 12);
        for (int k = 0; k < n; k++) srw_host_i.shift({12'h0, d0 + 28'(k)}, 28);
        srw_host_i.shift({12'h0, d0}, extra);
        srw_host_i.close_frame();
        repeat (20) @(posedge clk_in);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Serial traffic totals well under 100 us
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
    // Main sequence
    initial begin
        sys_rst_in = 1'b1;
        vertical_sync_in = 1'b1;
        frame_class_in = 1'b0;
        pat = 8'd3;
        sq = 8'd4;
        repeat (8) @(posedge clk_in);
        #1 sys_rst_in = 1'b0;
        check("counts", counts_out, 28'h0);
        check("bases", {seq_base_out, fld_base_out}, {12'h800, 12'h800});
        check("idle", {imm_valid_out, frm_valid_out, mapped_out}, 3'b000);
        // Counts write, then a continued word cut short
        frame(12'h028, {20'h0, sq, pat}, 1, 20);
        check("counts", counts_out, {20'h0, sq, pat});
        check("bases", {seq_base_out, fld_base_out}, {12'h890, 12'h930});
        check("nwr", 55'(seen.size()), 55'd1);
        check("w28", seen.pop_front(), ent(12'h028, {20'h0, sq, pat}));
        // One bit short of a word: nothing written
        frame(12'h028, 28'h0, 0, 27);
        check("short", 55'({8'(seen.size()), counts_out}), 55'({8'd0, 20'h0, sq, pat}));
        // Continuous writes across both region boundaries, then within the pattern area
        foreach (starts[j]) begin
            frame(starts[j], 28'h8a5c3e1, 2, 0);
            for (int k = 0; k < 2; k++) check("cont", seen.pop_front(), ent(starts[j] + 12'(k), 28'h8a5c3e1 + 28'(k)));
        end
        // Address between the two areas decodes as unmapped
        frame(12'h100, 28'h1, 1, 0);
        check("gap", mapped_out, 1'b0);
        seen.delete();
        // Frame-synchronised writes wait for vertical sync fall
        frame_class_in = 1'b1;
        frame(12'h850, 28'h1111111, 2, 0);
        check("held", 55'({8'(seen.size()), 8'(nfrm)}), 55'd0);
        vertical_sync_in = 1'b0;
        repeat (10) @(posedge clk_in);
        #1 vertical_sync_in = 1'b1;
        frame_class_in = 1'b0;
        check("frm", 55'({8'(nfrm), frm_addr_out, frm_data_out}), 55'({8'd1, 12'h851, 28'h1111112}));
        give_verdict();
    end
endmodule // srw_port_tb
`default_nettype wire
